// *** src/holdover_status_and_startup_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hold_map.svh"

module holdover_status_and_startup_control
  import hold_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  // Serial port
  input  wire logic sclk_in,
  input  wire logic cs_n_in,
  input  wire logic bidir_serial_line_in,
  output logic      bidir_serial_line_out,
  output logic      bidir_serial_line_oe_n_out,
  // PLL status, asynchronous
  input  wire logic holdover_live_n_in,
  input  wire logic synth_cal_active_in,
  input  wire logic reference_present_in,
  input  wire logic bias_cal_done_in,
  // Control strobes, bias calibration level and interrupt
  output logic      divider_init_out,
  output logic      force_pll_reacquire_out,
  output logic      bias_cal_start_out,
  output logic      irq_out_n
);

  ctl_state_t st;
  ctl_state_t next_st;
  logic [1:0] rst_pipe;
  logic       rst_n;
  logic       live_n_s;
  logic       cal_act_s;
  logic       ref_s;
  logic       done_s;
  logic       wr_tgl_s;
  logic       ack_s;
  logic       wr_tgl;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic       snap_ack;
  logic       wr_evt;

  // Reset release through two flops
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Idle reset levels, else reset looks like holdover
  bit_sync #(.WIDTH(6), .RST_VAL(`RST_SYNC)) u_sync (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n),
    .d_in     ({holdover_live_n_in, synth_cal_active_in,
                reference_present_in, bias_cal_done_in,
                wr_tgl, snap_ack}),
    .q_out    ({live_n_s, cal_act_s, ref_s, done_s, wr_tgl_s, ack_s})
  );

  // Write data is held stable by the link until its next frame
  spi_link u_link (
    .sclk_in      (sclk_in),
    .rst_n_in     (rst_b_in),
    .cs_n_in      (cs_n_in),
    .sdi_in       (bidir_serial_line_in),
    .sdo_out      (bidir_serial_line_out),
    .sdo_oe_n_out (bidir_serial_line_oe_n_out),
    .edge_sel_in  (st.edge_sel),
    .wr_tgl_out   (wr_tgl),
    .wr_addr_out  (wr_addr),
    .wr_data_out  (wr_data),
    .snap_req_in  (st.snap_req),
    .snap_in      (st.snap),
    .snap_ack_out (snap_ack)
  );

  function automatic logic hit(
    input logic       evt,
    input logic [6:0] a,
    input logic [6:0] want
  );
    return evt && (a == want);
  endfunction : hit

  assign wr_evt = wr_tgl_s != st.wr_seen;

  always_comb begin
    next_st = st;
    next_st.wr_seen  = wr_tgl_s;
    next_st.div_init = 1'h0;
    next_st.reacq    = 1'h0;
    if (hit(wr_evt, wr_addr, `ADDR_DIV_INIT)) begin
      next_st.div_init = wr_data[`BIT_STROBE];
    end
    if (hit(wr_evt, wr_addr, `ADDR_FORCE_PLL_REACQUIRE)) begin
      next_st.reacq = wr_data[`BIT_STROBE];
    end
    if (hit(wr_evt, wr_addr, `ADDR_BIAS)) begin
      next_st.edge_sel = wr_data[`BIT_EDGE];
    end
    if (hit(wr_evt, wr_addr, `ADDR_STATUS)) begin
      next_st.irq_en = wr_data[`BIT_IRQ_EN];
      if (wr_data[`BIT_LATCH]) begin
        next_st.latched_n = 1'h1;
      end
    end
    // live holdover sets latch every cycle, wins over clear
    if (!live_n_s) begin
      next_st.latched_n = 1'h0;
    end
    unique case (st.cal)
      BC_IDLE: begin
        if (hit(wr_evt, wr_addr, `ADDR_BIAS) && wr_data[`BIT_STROBE]) begin
          next_st.cal = BC_RUN;
        end
      end
      BC_RUN: begin
        if (done_s) begin
          next_st.cal = BC_IDLE;
        end
      end
    endcase
    next_st.irq_n = ~(next_st.irq_en & ~next_st.latched_n);
    // Snapshot refresh; stale by a few link clocks at most
    if (ack_s == st.snap_req) begin
      next_st.snap_req = ~st.snap_req;
      next_st.snap = {st.cal == BC_RUN, 6'h00, st.edge_sel,
                      st.irq_en, 3'h0, st.latched_n,
                      cal_act_s, ref_s, live_n_s};
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st           <= '0;
      st.cal       <= BC_IDLE;
      st.edge_sel  <= `RST_EDGE;
      st.irq_en    <= `RST_IRQ_EN;
      st.latched_n <= `RST_LATCH;
      st.irq_n     <= `RST_IRQ_N;
    end else begin
      st <= next_st;
    end
  end

  assign divider_init_out        = st.div_init;
  assign force_pll_reacquire_out = st.reacq;
  assign bias_cal_start_out      = st.cal == BC_RUN;
  assign irq_out_n               = st.irq_n;

  a_latch_on_hold : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    !live_n_s |=> !st.latched_n)
    else $error("holdover not latched");

  a_latch_stays : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (!st.latched_n
     && !(hit(wr_evt, wr_addr, `ADDR_STATUS) && wr_data[`BIT_LATCH]))
      |=> !st.latched_n)
    else $error("holdover latch lost without clear");

  a_latch_w1c : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (hit(wr_evt, wr_addr, `ADDR_STATUS) && wr_data[`BIT_LATCH] && live_n_s)
      |=> st.latched_n)
    else $error("latch not cleared by write one");

  a_latch_holds : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    $rose(st.latched_n) |-> $past(wr_evt))
    else $error("latch cleared without write");

  a_irq_withdrawn : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (hit(wr_evt, wr_addr, `ADDR_STATUS) && wr_data[`BIT_LATCH] && live_n_s)
      |=> irq_out_n)
    else $error("interrupt not withdrawn by clear");

  a_snap_live : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (ack_s == st.snap_req && !live_n_s) |=> !st.snap[`BIT_LIVE])
    else $error("live holdover bit not reported");

  a_snap_cal : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (ack_s == st.snap_req && cal_act_s) |=> st.snap[`BIT_CAL])
    else $error("calibration bit not reported");

  a_snap_ref : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (ack_s == st.snap_req && ref_s) |=> st.snap[`BIT_REF])
    else $error("reference bit not reported");

  a_irq_asserts : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (st.irq_en && !st.latched_n) |-> !irq_out_n)
    else $error("interrupt missing");

  a_irq_masked : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    !st.irq_en |-> irq_out_n)
    else $error("interrupt raised while disabled");

  a_div_start : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (hit(wr_evt, wr_addr, `ADDR_DIV_INIT) && wr_data[`BIT_STROBE])
      |=> divider_init_out)
    else $error("divider strobe not started");

  a_div_pulse : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    divider_init_out |=> !divider_init_out)
    else $error("divider strobe not single cycle");

  a_div_only_write : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    !(hit(wr_evt, wr_addr, `ADDR_DIV_INIT) && wr_data[`BIT_STROBE])
      |=> !divider_init_out)
    else $error("divider strobe without write");

  a_reacq_pulse : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (hit(wr_evt, wr_addr, `ADDR_FORCE_PLL_REACQUIRE) && wr_data[`BIT_STROBE])
      |=> force_pll_reacquire_out ##1 !force_pll_reacquire_out)
    else $error("reacquire strobe wrong");

  a_reacq_only_write : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    !(hit(wr_evt, wr_addr, `ADDR_FORCE_PLL_REACQUIRE) && wr_data[`BIT_STROBE])
      |=> !force_pll_reacquire_out)
    else $error("reacquire strobe without write");

  a_cal_start : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (hit(wr_evt, wr_addr, `ADDR_BIAS) && wr_data[`BIT_STROBE])
      |=> bias_cal_start_out)
    else $error("bias calibration not started");

  a_cal_no_start : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (!bias_cal_start_out
     && !(hit(wr_evt, wr_addr, `ADDR_BIAS) && wr_data[`BIT_STROBE]))
      |=> !bias_cal_start_out)
    else $error("bias calibration started without write");

  a_cal_holds : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (bias_cal_start_out && !done_s) |=> bias_cal_start_out)
    else $error("bias calibration dropped early");

  a_cal_ends : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (bias_cal_start_out && done_s) |=> !bias_cal_start_out)
    else $error("bias calibration did not end");

  a_edge_set : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    (hit(wr_evt, wr_addr, `ADDR_BIAS) && wr_data[`BIT_EDGE]) |=> st.edge_sel)
    else $error("read edge not set by write");

  a_edge_stable : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    !hit(wr_evt, wr_addr, `ADDR_BIAS) |=> $stable(st.edge_sel))
    else $error("read edge changed without write");

  a_edge_reset : assert property (
    @(posedge ref_clk_in) disable iff (!rst_n)
    $rose(rst_n) |-> !st.edge_sel)
    else $error("read edge not reset to zero");

endmodule : holdover_status_and_startup_control

`default_nettype wire

// *** src/hold_map.svh ***
`ifndef HOLD_MAP_SVH
`define HOLD_MAP_SVH

// Register addresses, 7-bit serial address space
`define ADDR_STATUS    7'h6E
`define ADDR_DIV_INIT  7'h71
`define ADDR_FORCE_PLL_REACQUIRE    7'h72
`define ADDR_BIAS      7'h73

// Bit positions
`define BIT_STROBE     7
`define BIT_EDGE       0
`define BIT_IRQ_EN     7
`define BIT_LATCH      3
`define BIT_CAL        2
`define BIT_REF        1
`define BIT_LIVE       0

// Reset values
`define RST_EDGE       1'h0
`define RST_IRQ_EN     1'h0
`define RST_LATCH      1'h1
`define RST_IRQ_N      1'h1
// Synced status idles, live holdover bit high
`define RST_SYNC       6'h20

// Frame bit counts, last index of each phase
`define ADDR_LAST      5'h07
`define FRAME_LAST     5'h0F

`endif

// *** src/hold_pkg.sv ***
package hold_pkg;

  typedef enum logic {
    BC_IDLE = 1'b0,
    BC_RUN  = 1'b1
  } bias_cal_state_t;

  typedef struct packed {
    bias_cal_state_t cal;
    logic            edge_sel;
    logic            irq_en;
    logic            latched_n;
    logic            irq_n;
    logic            div_init;
    logic            reacq;
    logic            wr_seen;
    logic            snap_req;
    logic [15:0]     snap;
  } ctl_state_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic       rw;
    logic [6:0] addr;
    logic [6:0] shin;
    logic       rd_phase;
    logic [7:0] rd_sh;
  } frame_state_t;

  typedef struct packed {
    logic       wr_tgl;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic       ack;
    logic [15:0] snap;
  } link_state_t;

endpackage : hold_pkg

// *** src/bit_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta  <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule : bit_sync

`default_nettype wire

// *** src/spi_link.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hold_map.svh"

module spi_link
  import hold_pkg::*;
(
  // Link clock and frame
  input  wire logic        sclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        cs_n_in,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             sdo_oe_n_out,
  // Read edge, level from core
  input  wire logic        edge_sel_in,
  // Write handoff to core
  output logic             wr_tgl_out,
  output logic [6:0]       wr_addr_out,
  output logic [7:0]       wr_data_out,
  // Snapshot handshake
  input  wire logic        snap_req_in,
  input  wire logic [15:0] snap_in,
  output logic             snap_ack_out
);

  frame_state_t fr;
  frame_state_t next_fr;
  link_state_t  lk;
  link_state_t  next_lk;
  logic         frame_rst_n;
  logic         edge_s;
  logic         req_s;
  logic         fall_q;

  // Frame logic ends with chip select, not with a clock edge
  assign frame_rst_n = rst_n_in & ~cs_n_in;

  bit_sync #(.WIDTH(2)) u_sync (
    .clk_in   (sclk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({edge_sel_in, snap_req_in}),
    .q_out    ({edge_s, req_s})
  );

  function automatic logic [7:0] read_byte(
    input logic [6:0]  a,
    input logic [15:0] s
  );
    logic [7:0] r;
    r = 8'h00;
    if (a == `ADDR_STATUS) begin
      r = s[7:0];
    end else if (a == `ADDR_BIAS) begin
      r = s[15:8];
    end
    return r;
  endfunction : read_byte

  always_comb begin
    next_fr = fr;
    next_lk = lk;
    next_fr.cnt = fr.cnt + 5'h01;
    if (fr.cnt == 5'h00) begin
      next_fr.rw = sdi_in;
    end else if (fr.cnt <= `ADDR_LAST) begin
      next_fr.addr = {fr.addr[5:0], sdi_in};
    end else begin
      next_fr.shin = {fr.shin[5:0], sdi_in};
    end
    if (fr.rd_phase) begin
      next_fr.rd_sh = {fr.rd_sh[6:0], 1'h0};
    end
    if (fr.cnt == `ADDR_LAST && fr.rw) begin
      next_fr.rd_phase = 1'h1;
      next_fr.rd_sh    = read_byte({fr.addr[5:0], sdi_in}, lk.snap);
    end
    // Full write frame commits one write to the core
    if (fr.cnt == `FRAME_LAST && !fr.rw) begin
      next_lk.wr_tgl  = ~lk.wr_tgl;
      next_lk.wr_addr = fr.addr;
      next_lk.wr_data = {fr.shin, sdi_in};
    end
    if (req_s != lk.ack) begin
      next_lk.snap = snap_in;
      next_lk.ack  = req_s;
    end
  end

  always_ff @(posedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr <= '0;
    end else begin
      fr <= next_fr;
    end
  end

  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // Falling-edge copy for the default read edge
  always_ff @(negedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fall_q <= 1'h0;
    end else begin
      fall_q <= fr.rd_sh[7];
    end
  end

  assign sdo_out      = edge_s ? fr.rd_sh[7] : fall_q;
  assign sdo_oe_n_out = ~fr.rd_phase;
  assign wr_tgl_out   = lk.wr_tgl;
  assign wr_addr_out  = lk.wr_addr;
  assign wr_data_out  = lk.wr_data;
  assign snap_ack_out = lk.ack;

  a_oe_read_phase : assert property (
    @(posedge sclk_in) disable iff (!frame_rst_n)
    (fr.cnt == `ADDR_LAST && fr.rw) |=> !sdo_oe_n_out)
    else $error("read data not driven after address");

endmodule : spi_link

`default_nettype wire

// *** tb/spi_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module spi_host (
  // Serial port
  output logic       sclk_out,
  output logic       cs_n_out,
  output logic       sdi_out,
  output logic       sdi_oe_out,
  input  wire logic  line_in
);
  initial begin
    sclk_out   = 1'b0;
    cs_n_out   = 1'b1;
    sdi_out    = 1'b0;
    sdi_oe_out = 1'b0;
  end

  // Clock stands low between frames
  task automatic xfer(input logic rw, input logic [6:0] addr,
                      input logic [7:0] wdat, input logic edge_m,
                      output logic [7:0] rdat);
    logic [15:0] frm;
    frm  = {rw, addr, wdat};
    rdat = 8'h00;
    #3 cs_n_out = 1'b0;
    for (int i = 0; i < 16; i++) begin
      // Released for read data
      sdi_oe_out = !(rw && i >= 8);
      sdi_out    = frm[15-i];
      #40;
      if (rw && !edge_m && i >= 8) rdat = {rdat[6:0], line_in};
      sclk_out = 1'b1;
      #40;
      if (rw && edge_m && i >= 7 && i < 15) rdat = {rdat[6:0], line_in};
      sclk_out = 1'b0;
    end
    #40 cs_n_out = 1'b1;
    sdi_oe_out = 1'b0;
    // Gap keeps writes well apart
    #200;
  endtask : xfer
endmodule : spi_host

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hold_map.svh"

module tb;
  logic       ref_clk_in;
  logic       rst_b_in;
  logic       sclk, cs_n, sdi, sdi_oe, line;
  logic       dut_out, dut_oe_n;
  logic       live_n, cal_act, ref_ok, bias_done;
  logic       div_init, reacq, bias_start, irq_n;
  logic [7:0] rd;
  logic       edge_m;
  int         n_errors, comparisons, n_div, n_rel;

  // Pull-up wins when nobody drives
  assign line = !dut_oe_n ? dut_out : (sdi_oe ? sdi : 1'b1);

  holdover_status_and_startup_control dut (
    .ref_clk_in                 (ref_clk_in),
    .rst_b_in                   (rst_b_in),
    .sclk_in                    (sclk),
    .cs_n_in                    (cs_n),
    .bidir_serial_line_in       (line),
    .bidir_serial_line_out      (dut_out),
    .bidir_serial_line_oe_n_out (dut_oe_n),
    .holdover_live_n_in         (live_n),
    .synth_cal_active_in        (cal_act),
    .reference_present_in       (ref_ok),
    .bias_cal_done_in           (bias_done),
    .divider_init_out           (div_init),
    .force_pll_reacquire_out    (reacq),
    .bias_cal_start_out         (bias_start),
    .irq_out_n                  (irq_n)
  );

  spi_host host (
    .sclk_out   (sclk),
    .cs_n_out   (cs_n),
    .sdi_out    (sdi),
    .sdi_oe_out (sdi_oe),
    .line_in    (line)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    if (div_init === 1'b1) n_div++;
    if (reacq === 1'b1) n_rel++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] got,
                     input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, edge_m, rd);
    // Realign stimulus to the core clock
    tick(1);
  endtask : wr

  // First frame refreshes the snapshot
  task automatic rd_chk(input string nm, input logic [6:0] a,
                        input logic [7:0] exp);
    host.xfer(1'b1, a, 8'h00, edge_m, rd);
    host.xfer(1'b1, a, 8'h00, edge_m, rd);
    tick(1);
    chk(nm, rd, exp);
  endtask : rd_chk

  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic wait_bias(input logic v);
    for (int k = 0; k < 100 && bias_start !== v; k++) tick(1);
    chk("bias_start", {7'h00, bias_start}, {7'h00, v});
    if (bias_start !== v) report_and_stop();
  endtask : wait_bias

  initial begin
    #500000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    n_errors = 0;
    comparisons = 0;
    n_div = 0;
    n_rel = 0;
    rst_b_in = 1'b0;
    live_n = 1'b1;
    cal_act = 1'b1;
    ref_ok = 1'b1;
    bias_done = 1'b0;
    edge_m = 1'b0;
    tick(4);
    rst_b_in = 1'b1;
    tick(6);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    rd_chk("bias_reg", `ADDR_BIAS, 8'h00);
    rd_chk("status", `ADDR_STATUS, 8'h0F);
    $display("test reset done");
    wr(`ADDR_DIV_INIT, 8'h80);
    tick(8);
    chk("div_pulses", 8'(n_div), 8'h01);
    chk("reacq_pulses", 8'(n_rel), 8'h00);
    wr(`ADDR_FORCE_PLL_REACQUIRE, 8'hFF);
    tick(8);
    chk("reacq_pulses", 8'(n_rel), 8'h01);
    chk("div_pulses", 8'(n_div), 8'h01);
    wr(`ADDR_DIV_INIT, 8'h7F);
    tick(8);
    chk("div_pulses", 8'(n_div), 8'h01);
    rd_chk("div_reg", `ADDR_DIV_INIT, 8'h00);
    rd_chk("reacq_reg", `ADDR_FORCE_PLL_REACQUIRE, 8'h00);
    $display("test strobes done");
    wr(`ADDR_BIAS, 8'h81);
    edge_m = 1'b1;
    wait_bias(1'b1);
    rd_chk("bias_run", `ADDR_BIAS, 8'h81);
    tick(1);
    bias_done = 1'b1;
    wait_bias(1'b0);
    tick(1);
    bias_done = 1'b0;
    rd_chk("bias_idle", `ADDR_BIAS, 8'h01);
    wr(`ADDR_BIAS, 8'h7E);
    edge_m = 1'b0;
    chk("bias_start", {7'h00, bias_start}, 8'h00);
    rd_chk("bias_rsvd", `ADDR_BIAS, 8'h00);
    $display("test bias done");
    wr(`ADDR_STATUS, 8'h80);
    live_n = 1'b0;
    tick(6);
    chk("irq_n", {7'h00, irq_n}, 8'h00);
    rd_chk("hold_live", `ADDR_STATUS, 8'h86);
    live_n = 1'b1;
    rd_chk("hold_latched", `ADDR_STATUS, 8'h87);
    wr(`ADDR_STATUS, 8'h88);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    rd_chk("hold_clear", `ADDR_STATUS, 8'h8F);
    cal_act = 1'b0;
    ref_ok = 1'b0;
    wr(`ADDR_STATUS, 8'h00);
    live_n = 1'b0;
    tick(6);
    live_n = 1'b1;
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    rd_chk("status_low", `ADDR_STATUS, 8'h01);
    $display("test holdover done");
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
